//--- logic/nbh_host.sv
// host-side nand bus sequencer driving the flash pins
// What this block does
// - chip select driven low to select
// - write strobe pulsed low, captured on rise
// - command latch high marks command byte
// - address latch high marks address byte
// - host holds protect low during reset
// - one shared eight-bit two-way port
// - address is five cycles, two column
// - column cycles carry bits 7:0, 12:8
// - row cycles carry 20:13, 28:21, 30:29
// - column 11:8 forced zero when 12 set
`timescale 1ns/100ps
module nbh_host (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // user request
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire nbh_pkg::nbh_op_t i_req_op,
  input wire logic [7:0] i_req_byte,
  input wire logic [nbh_pkg::NBH_ADDR_W-1:0] i_req_addr,
  input wire logic i_wp_release,
  // user answer
  output logic o_rd_valid,
  output logic [7:0] o_rd_byte,
  output logic o_busy,
  output logic [nbh_pkg::NBH_ADDR_W-1:0] o_addr_sent,
  // flash pins
  output logic o_ce_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_read_strobe_n,
  output logic o_wp_n,
  input wire logic i_ready_busy_n,
  input wire logic [7:0] i_shared_byte_port,
  output logic [7:0] o_shared_byte_port,
  output logic o_shared_byte_port_oe
);
  import nbh_pkg::*;
  // ********************************
  // address cycle packing
  // ********************************
  function automatic logic [7:0] addr_cycle(input logic [NBH_ADDR_W-1:0] a,
                                            input logic [2:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      3'h0: b = a[7:0];
      3'h1: b = {3'h0, a[12:8]};
      3'h2: b = a[20:13];
      3'h3: b = a[28:21];
      3'h4: b = {6'h00, a[30:29]};
      default: b = 8'h00;
    endcase
    return b;
  endfunction : addr_cycle
  function automatic logic [NBH_ADDR_W-1:0] fix_col(input logic [NBH_ADDR_W-1:0] a);
    logic [NBH_ADDR_W-1:0] r;
    r = a;
    if (a[NBH_COL_HI_BIT]) begin
      r[11:8] = 4'h0;
    end
    return r;
  endfunction : fix_col
  // ********************************
  // pin input synchronisers
  // ********************************
  logic rb_m_q, rb_s_q;
  logic [7:0] dq_m_q, dq_s_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rb_m_q <= 1'b1;
      rb_s_q <= 1'b1;
      dq_m_q <= 8'h00;
      dq_s_q <= 8'h00;
    end else begin
      rb_m_q <= i_ready_busy_n;
      rb_s_q <= rb_m_q;
      dq_m_q <= i_shared_byte_port;
      dq_s_q <= dq_m_q;
    end
  end
  // ********************************
  // sequencer
  // ********************************
  typedef enum {NBH_S_IDLE, NBH_S_STROBE, NBH_S_SAMPLE} nbh_state_t;
  nbh_state_t state_q, state_d;
  nbh_op_t op_q, op_d;
  logic [7:0] dout_q, dout_d;
  logic [7:0] rbyte_q, rbyte_d;
  logic rvalid_q, rvalid_d;
  logic [2:0] acyc_q, acyc_d;
  logic [NBH_ADDR_W-1:0] addr_q, addr_d;
  logic ce_n_q, ce_n_d;
  logic wp_n_q, wp_n_d;
  logic [1:0] wait_q, wait_d;
  nbh_strobe_if st ();
  nbh_strobe_timer u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .st(st)
  );
  assign o_req_ready = (state_q == NBH_S_IDLE);
  assign st.start = (state_q == NBH_S_IDLE) && i_req_valid;
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    dout_d = dout_q;
    rbyte_d = rbyte_q;
    rvalid_d = 1'b0;
    acyc_d = acyc_q;
    addr_d = addr_q;
    ce_n_d = ce_n_q;
    wait_d = wait_q;
    // protect stays low until the user releases it
    wp_n_d = wp_n_q | i_wp_release;
    case (state_q)
      NBH_S_IDLE: begin
        if (i_req_valid) begin
          state_d = NBH_S_STROBE;
          op_d = i_req_op;
          // select the device for the transfer
          ce_n_d = 1'b0;
          case (i_req_op)
            NBH_OP_ADDR: begin
              // five cycles from one latched address
              if (acyc_q == 3'h0) begin
                addr_d = fix_col(i_req_addr);
                dout_d = addr_cycle(fix_col(i_req_addr), 3'h0);
              end else begin
                dout_d = addr_cycle(addr_q, acyc_q);
              end
              acyc_d = (acyc_q == 3'(NBH_ADDR_CYCLES - 1)) ? 3'h0 : acyc_q + 3'h1;
            end
            NBH_OP_CMD: begin
              dout_d = i_req_byte;
              acyc_d = 3'h0;
            end
            default: dout_d = i_req_byte;
          endcase
        end else if (rb_s_q) begin
          // deselect when idle and the device is ready; while busy shows, chip select keeps its level
          ce_n_d = 1'b1;
        end
      end
      NBH_S_STROBE: begin
        if (st.done) begin
          if (op_q == NBH_OP_RDATA) begin
            state_d = NBH_S_SAMPLE;
            wait_d = 2'h2;
          end else begin
            state_d = NBH_S_IDLE;
          end
        end
      end
      NBH_S_SAMPLE: begin
        // data stays driven while strobe is high; synchroniser latency covered here
        if (wait_q == 2'h0) begin
          rbyte_d = dq_s_q;
          rvalid_d = 1'b1;
          state_d = NBH_S_IDLE;
        end else begin
          wait_d = wait_q - 2'h1;
        end
      end
      default: state_d = NBH_S_IDLE;
    endcase
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q <= NBH_S_IDLE;
      op_q <= NBH_OP_CMD;
      dout_q <= 8'h00;
      rbyte_q <= 8'h00;
      rvalid_q <= 1'b0;
      acyc_q <= 3'h0;
      addr_q <= '0;
      ce_n_q <= 1'b1;
      wp_n_q <= 1'b0;
      wait_q <= 2'h0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      dout_q <= dout_d;
      rbyte_q <= rbyte_d;
      rvalid_q <= rvalid_d;
      acyc_q <= acyc_d;
      addr_q <= addr_d;
      ce_n_q <= ce_n_d;
      wp_n_q <= wp_n_d;
      wait_q <= wait_d;
    end
  end
  // ********************************
  // pin drive
  // ********************************
  logic strobing;
  assign strobing = (state_q == NBH_S_STROBE);
  assign o_ce_n = ce_n_q;
  // command latch only on command cycles
  assign o_cle = strobing && (op_q == NBH_OP_CMD);
  // address latch only on address cycles
  assign o_ale = strobing && (op_q == NBH_OP_ADDR);
  // write strobe low phase; device captures on its rise
  assign o_we_n = !(strobing && st.phase_low && (op_q != NBH_OP_RDATA));
  // one read strobe fall per data byte
  assign o_read_strobe_n = !(strobing && st.phase_low && (op_q == NBH_OP_RDATA));
  assign o_wp_n = wp_n_q;
  // drive the shared port only during strobes that are not reads
  assign o_shared_byte_port = dout_q;
  assign o_shared_byte_port_oe = strobing && (op_q != NBH_OP_RDATA);
  assign o_rd_valid = rvalid_q;
  assign o_rd_byte = rbyte_q;
  // busy seen from the synchronised ready/busy pin
  assign o_busy = !rb_s_q;
  assign o_addr_sent = addr_q;
endmodule : nbh_host

//--- logic/nbh_pkg.sv
// package of pin-level constants for the nand bus host
package nbh_pkg;
  // ********************************
  // geometry
  // ********************************
  localparam int NBH_PAGES_PER_BLOCK = 64;
  localparam int NBH_MAIN_BYTES = 4096;
  localparam int NBH_SPARE_BYTES = 256;
  localparam int NBH_PAGE_BYTES = NBH_MAIN_BYTES + NBH_SPARE_BYTES;
  localparam int NBH_ADDR_CYCLES = 5;
  localparam int NBH_ADDR_W = 31;
  localparam int NBH_COL_HI_BIT = 12;
  localparam int NBH_PLANE_BIT = 19;
  localparam int NBH_DIE_BIT = 30;
  // ********************************
  // timing at 25 MHz
  // ********************************
  localparam int NBH_CLK_MHZ = 25;
  localparam int NBH_STROBE_LOW_NS = 40;
  localparam int NBH_STROBE_HIGH_NS = 40;
  localparam int NBH_STROBE_LOW_CYC =
    (NBH_STROBE_LOW_NS * NBH_CLK_MHZ + 999) / 1000 < 1 ? 1 :
    (NBH_STROBE_LOW_NS * NBH_CLK_MHZ + 999) / 1000;
  localparam int NBH_STROBE_HIGH_CYC =
    (NBH_STROBE_HIGH_NS * NBH_CLK_MHZ + 999) / 1000 < 1 ? 1 :
    (NBH_STROBE_HIGH_NS * NBH_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] NBH_CNT_ZERO = 4'h0;
  // ********************************
  // operation codes on the user port
  // ********************************
  typedef enum logic [1:0] {
    NBH_OP_CMD = 2'h0,
    NBH_OP_ADDR = 2'h1,
    NBH_OP_WDATA = 2'h2,
    NBH_OP_RDATA = 2'h3
  } nbh_op_t;
endpackage : nbh_pkg

//--- logic/nbh_strobe_if.sv
// interface between the host sequencer and its strobe timer
`timescale 1ns/100ps
interface nbh_strobe_if;
  logic start;
  logic phase_low;
  logic done;
  modport master (output start, input phase_low, input done);
  modport timer (input start, output phase_low, output done);
endinterface : nbh_strobe_if

//--- logic/nbh_strobe_timer.sv
// strobe low/high phase timer
`timescale 1ns/100ps
module nbh_strobe_timer (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // control
  nbh_strobe_if.timer st
);
  import nbh_pkg::*;
  typedef enum {NBH_T_IDLE, NBH_T_LOW, NBH_T_HIGH} nbh_tstate_t;
  nbh_tstate_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      NBH_T_IDLE: begin
        if (st.start) begin
          state_d = NBH_T_LOW;
          cnt_d = 4'(NBH_STROBE_LOW_CYC - 1);
        end
      end
      NBH_T_LOW: begin
        if (cnt_q == NBH_CNT_ZERO) begin
          state_d = NBH_T_HIGH;
          cnt_d = 4'(NBH_STROBE_HIGH_CYC - 1);
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      NBH_T_HIGH: begin
        if (cnt_q == NBH_CNT_ZERO) begin
          state_d = NBH_T_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: state_d = NBH_T_IDLE;
    endcase
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q <= NBH_T_IDLE;
      cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end
  assign st.phase_low = (state_q == NBH_T_LOW);
  assign st.done = (state_q == NBH_T_HIGH) && (cnt_q == NBH_CNT_ZERO);
endmodule : nbh_strobe_timer

//--- tb/nbh_monitor.sv
// pin checks on the nand bus host
`timescale 1ns/100ps
module nbh_monitor (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // pins
  input wire logic o_ce_n,
  input wire logic o_cle,
  input wire logic o_ale,
  input wire logic o_we_n,
  input wire logic o_read_strobe_n,
  input wire logic o_wp_n,
  input wire logic o_shared_byte_port_oe,
  input wire logic i_ready_busy_n,
  input wire logic o_busy,
  input wire logic o_rd_valid
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  latch_excl_a: assert property (!(o_cle && o_ale))
    else $error("both latch enables high");
  we_pulse_a: assert property ($fell(o_we_n) |=> $rose(o_we_n))
    else $error("write strobe not one cycle");
  latch_hold_a: assert property ($rose(o_we_n) |-> $stable(o_cle) && $stable(o_ale)
    && o_shared_byte_port_oe) else $error("latch or byte dropped at capture");
  rd_valid_a: assert property ($fell(o_read_strobe_n) |-> ##5 o_rd_valid)
    else $error("read byte late");
  rd_float_a: assert property (!o_read_strobe_n |-> !o_shared_byte_port_oe && o_we_n)
    else $error("port driven during read");
  sel_low_a: assert property (!o_we_n || !o_read_strobe_n |-> !o_ce_n)
    else $error("strobe while deselected");
  busy_sync_a: assert property (!i_ready_busy_n [*3] |-> o_busy)
    else $error("busy not seen");
  // deselect is decided on the busy view of the cycle before the rise
  busy_desel_a: assert property ($rose(o_ce_n) |-> !$past(o_busy))
    else $error("deselect while busy");
  wp_keep_a: assert property (o_wp_n |=> o_wp_n)
    else $error("protect fell without reset");
  cover property ($fell(o_read_strobe_n));
  cover property ($rose(o_we_n) && o_ale);
  cover property (o_busy && o_ce_n);
endmodule : nbh_monitor

//--- tb/nbh_flash_model.sv
// behavioural flash device on the pins
`timescale 1ns/100ps
module nbh_flash_model import nbh_pkg::*; #(
  parameter logic [7:0] START_CMD = 8'h5A,
  parameter int BUSY_NS = 800
) (
  // flash pins
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_read_strobe_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_port,
  output logic [7:0] o_port,
  output logic o_port_oe,
  output logic o_pull_low
);
  logic [7:0] cmd_q = 8'hFF;
  logic [7:0] data_q = 8'h00;
  logic [7:0] abyte [5];
  logic [12:0] col_q = 13'h0000;
  int n_addr = 0;
  logic standby;
  initial o_port = 8'h00;
  initial o_port_oe = 1'b0;
  initial o_pull_low = 1'b0;
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle) begin
      cmd_q = i_port;
      n_addr = 0;
      if (i_port === START_CMD && i_wp_n) begin
        o_pull_low = 1'b1;
        o_pull_low <= #(BUSY_NS) 1'b0;
      end
    end else if (!i_ce_n && i_ale) begin
      if (n_addr == 1) col_q = {i_port[4:0], abyte[0]};
      abyte[n_addr % 5] = i_port;
      n_addr = n_addr + 1;
    end else if (!i_ce_n) begin
      data_q = i_port;
    end
  end
  always @(negedge i_read_strobe_n) begin
    if (!i_ce_n) begin
      o_port = col_q[7:0] ^ 8'hC3;
      o_port_oe = 1'b1;
      col_q = (col_q == 13'(NBH_PAGE_BYTES - 1)) ? 13'h0000 : col_q + 13'h0001;
    end
  end
  always @(posedge i_ce_n or negedge i_we_n) o_port_oe = 1'b0;
  assign standby = i_ce_n && !o_pull_low;
endmodule : nbh_flash_model

//--- tb/nbh_host_tb.sv
// self-checking bench for the nand bus host
`timescale 1ns/100ps
module nbh_host_tb;
  import nbh_pkg::*;
  logic clk, rst, vld, rel, rdy, rv, busy, ce_n, cle, ale, we_n, rs_n, wp_n, hoe, foe, pull;
  nbh_op_t op;
  logic [7:0] wb, rdb, hq, fq;
  logic [7:0] last = 8'h00;
  logic [30:0] ad, sent;
  int n_errors = 0;
  int samples_checked = 0;
  // released bus shows the inverse of its last value
  wire logic [7:0] bus = hoe ? hq : (foe ? fq : ~last);
  always @(bus) if (hoe || foe) last = bus;
  nbh_host nbh_host_inst (.i_clk_sys(clk), .i_rst(rst), .i_req_valid(vld), .o_req_ready(rdy),
    .i_req_op(op), .i_req_byte(wb), .i_req_addr(ad), .i_wp_release(rel), .o_rd_valid(rv),
    .o_rd_byte(rdb), .o_busy(busy), .o_addr_sent(sent), .o_ce_n(ce_n), .o_cle(cle),
    .o_ale(ale), .o_we_n(we_n), .o_read_strobe_n(rs_n), .o_wp_n(wp_n),
    .i_ready_busy_n(!pull), .i_shared_byte_port(bus), .o_shared_byte_port(hq),
    .o_shared_byte_port_oe(hoe));
  nbh_flash_model nbh_flash_model_inst (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale),
    .i_we_n(we_n), .i_read_strobe_n(rs_n), .i_wp_n(wp_n), .i_port(bus), .o_port(fq),
    .o_port_oe(foe), .o_pull_low(pull));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [30:0] got, input logic [30:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic req(input nbh_op_t o, input logic [7:0] b);
    @(negedge clk);
    op = o;
    wb = b;
    vld = 1'b1;
    for (int k = 0; k < 50 && rdy !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    vld = 1'b0;
    // the strobe rises one cycle after the take; wait for idle so the capture has landed
    for (int k = 0; k < 50 && rdy !== 1'b1; k++) @(negedge clk);
  endtask : req
  task automatic wait_rd;
    for (int k = 0; k < 20 && rv !== 1'b1; k++) @(negedge clk);
  endtask : wait_rd
  task automatic t_protect;
    req(NBH_OP_CMD, 8'h5A);
    repeat (10) @(negedge clk);
    chk(busy, 1'b0);
    chk(wp_n, 1'b0);
    rel = 1'b1;
    req(NBH_OP_CMD, 8'h5A);
    rel = 1'b0;
    repeat (6) @(negedge clk);
    chk(busy, 1'b1);
    chk(nbh_flash_model_inst.standby, 1'b0);
    for (int k = 0; k < 60 && busy !== 1'b0; k++) @(negedge clk);
    repeat (4) @(negedge clk);
    chk(ce_n, 1'b1);
    chk(nbh_flash_model_inst.standby, 1'b1);
  endtask : t_protect
  task automatic t_address;
    ad = 31'h4B5A_1F34;
    req(NBH_OP_CMD, 8'h00);
    repeat (5) req(NBH_OP_ADDR, 8'h00);
    chk(nbh_flash_model_inst.cmd_q, 8'h00);
    chk(sent, 31'h4B5A_1034);
    chk(nbh_flash_model_inst.abyte[0], 8'h34);
    chk(nbh_flash_model_inst.abyte[1], 8'h10);
    chk(nbh_flash_model_inst.abyte[2], 8'hD0);
    chk(nbh_flash_model_inst.abyte[3], 8'h5A);
    chk(nbh_flash_model_inst.abyte[4], 8'h02);
  endtask : t_address
  task automatic t_write_read;
    req(NBH_OP_WDATA, 8'hA7);
    chk(nbh_flash_model_inst.data_q, 8'hA7);
    req(NBH_OP_RDATA, 8'h00);
    wait_rd();
    chk(rv, 1'b1);
    chk(rdb, 8'hF7);
    @(negedge clk);
    chk(rv, 1'b0);
    req(NBH_OP_RDATA, 8'h00);
    wait_rd();
    chk(rdb, 8'hF6);
  endtask : t_write_read
  task automatic end_of_test;
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial begin
    rst = 1'b1;
    vld = 1'b0;
    rel = 1'b0;
    op = NBH_OP_CMD;
    wb = 8'h00;
    ad = 31'h0000_0000;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_protect();
    t_address();
    t_write_read();
    end_of_test();
  end
  initial begin
    #40000;
    n_errors++;
    end_of_test();
  end
endmodule : nbh_host_tb
bind nbh_host nbh_monitor nbh_monitor_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n),
  .o_read_strobe_n(o_read_strobe_n), .o_wp_n(o_wp_n),
  .o_shared_byte_port_oe(o_shared_byte_port_oe), .i_ready_busy_n(i_ready_busy_n),
  .o_busy(o_busy), .o_rd_valid(o_rd_valid));
